// ===== hdl/link_pkg.sv
// link_pkg: constants, message table and state codes of the secondary
// link state machine; assumes a 10 MHz system clock and byte-wide frames
`default_nettype none

package link_pkg;
	// clock and no-frame timeout
	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned TIMEOUT_MS  = 3000;
	localparam int unsigned TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;

	// framing characters and addresses
	localparam logic [7:0] BOF_CHAR   = 8'hC0;
	localparam logic [7:0] EOF_CHAR   = 8'hC1;
	localparam logic [7:0] BCAST_ADDR = 8'hFF;
	localparam logic [7:0] BCAST_SLOT = 8'hFF; // slot field of the id packet
	localparam logic [7:0] SLOT_ZERO  = 8'h00;

	// control bytes
	localparam logic [7:0] CTL_XID     = 8'h3F;
	localparam logic [7:0] CTL_XID_RSP = 8'hBF;
	localparam logic [7:0] CTL_SNRM    = 8'h93;
	localparam logic [7:0] CTL_DISC    = 8'h53;
	localparam logic [7:0] CTL_UA      = 8'h73;
	localparam logic [7:0] CTL_RR      = 8'h11;
	localparam logic [7:0] CTL_REJ     = 8'h19;
	localparam logic [7:0] CTL_INFO    = 8'h10;

	// service query kinds (first info byte of an info frame)
	localparam logic [7:0] QRY_NAME = 8'h01;
	localparam logic [7:0] QRY_ADDR = 8'h02;
	localparam logic [7:0] QRY_CAPS = 8'h03;

	// reply payload bytes; the name code is arbitrary
	localparam logic [7:0] HINT_MODEM = 8'h04;
	localparam logic [7:0] PARAM_RATE = 8'h01;
	localparam logic [7:0] PARAM_LEN  = 8'h01;
	localparam logic [7:0] RATE_BITS  = 8'h02; // one bit set: 9600 only
	localparam logic [7:0] NAME_CODE  = 8'h53;
	localparam logic [7:0] SVC_ADDR   = 8'h03;
	localparam logic [1:0] RATE_9600  = 2'h1;

	// canned replies held in the reply memory
	typedef enum logic [2:0] {
		MSG_XID   = 3'h0,
		MSG_PARAM = 3'h1,
		MSG_NAME  = 3'h2,
		MSG_ADDR  = 3'h3,
		MSG_CAPS  = 3'h4,
		MSG_RR    = 3'h5,
		MSG_UA    = 3'h6,
		MSG_REJ   = 3'h7
	} msg_t;
	localparam logic [4:0] MSG_BASE [8] = '{5'h00, 5'h04, 5'h09, 5'h0D,
		5'h11, 5'h15, 5'h17, 5'h19};
	localparam logic [2:0] MSG_LEN [8] = '{3'h4, 3'h5, 3'h4, 3'h4,
		3'h4, 3'h2, 3'h2, 3'h2};

	typedef enum logic [2:0] {
		ST_DISCONNECTED = 3'b001,
		ST_DISCOVERY    = 3'b010,
		ST_CONNECTED    = 3'b100
	} link_state_t;

	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_BOF  = 4'b0010,
		TX_BODY = 4'b0100,
		TX_EOF  = 4'b1000
	} tx_state_t;
endpackage

`default_nettype wire

// ===== hdl/reply_rom.sv
// reply_rom: byte image of every canned reply frame body
// assumes the reader presents the address one cycle before it needs data
`default_nettype none

module reply_rom (
	input  wire logic       sys_clk,
	input  wire logic [4:0] romAddr,
	output logic      [7:0] romData
);
	// registered read, so data trail the address by one clock
	always_ff @(posedge sys_clk) begin
		case (romAddr)
			5'h00: romData <= link_pkg::BCAST_ADDR;
			5'h01: romData <= link_pkg::CTL_XID_RSP;
			5'h02: romData <= link_pkg::SLOT_ZERO;
			5'h03: romData <= link_pkg::HINT_MODEM;
			5'h04: romData <= link_pkg::BCAST_ADDR;
			5'h05: romData <= link_pkg::CTL_UA;
			5'h06: romData <= link_pkg::PARAM_RATE;
			5'h07: romData <= link_pkg::PARAM_LEN;
			5'h08: romData <= link_pkg::RATE_BITS;
			5'h09: romData <= link_pkg::BCAST_ADDR;
			5'h0A: romData <= link_pkg::CTL_INFO;
			5'h0B: romData <= link_pkg::QRY_NAME;
			5'h0C: romData <= link_pkg::NAME_CODE;
			5'h0D: romData <= link_pkg::BCAST_ADDR;
			5'h0E: romData <= link_pkg::CTL_INFO;
			5'h0F: romData <= link_pkg::QRY_ADDR;
			5'h10: romData <= link_pkg::SVC_ADDR;
			5'h11: romData <= link_pkg::BCAST_ADDR;
			5'h12: romData <= link_pkg::CTL_INFO;
			5'h13: romData <= link_pkg::QRY_CAPS;
			5'h14: romData <= link_pkg::HINT_MODEM;
			5'h15: romData <= link_pkg::BCAST_ADDR;
			5'h16: romData <= link_pkg::CTL_RR;
			5'h17: romData <= link_pkg::BCAST_ADDR;
			5'h18: romData <= link_pkg::CTL_UA;
			5'h19: romData <= link_pkg::BCAST_ADDR;
			5'h1A: romData <= link_pkg::CTL_REJ;
			default: romData <= 8'h00;
		endcase
	end
endmodule

`default_nettype wire

// ===== hdl/frame_parser.sv
// frame_parser: picks address, control and first info byte out of frames
// assumes a byte decoder on sys_clk giving one-cycle rxValid strobes
`default_nettype none

module frame_parser (
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic [7:0] rxByte,
	input  wire logic       rxValid,
	input  wire logic       rxCrcOk,
	output logic            frameDone,
	output logic      [7:0] frameAddr,
	output logic      [7:0] frameCtrl,
	output logic      [7:0] frameInfo,
	output logic            frameOk
);
	logic       inFrame;
	logic [1:0] fieldPos; // 0 addr, 1 ctrl, 2 first info, 3 the rest

	// repeated start characters simply restart the frame
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			inFrame   <= 1'b0;
			fieldPos  <= 2'h0;
			frameDone <= 1'b0;
			frameAddr <= 8'h00;
			frameCtrl <= 8'h00;
			frameInfo <= 8'h00;
			frameOk   <= 1'b0;
		end else begin
			frameDone <= 1'b0;
			if (rxValid) begin
				if (rxByte == link_pkg::BOF_CHAR) begin
					inFrame   <= 1'b1;
					fieldPos  <= 2'h0;
					frameInfo <= 8'h00;
				end else if (rxByte == link_pkg::EOF_CHAR) begin
					inFrame   <= 1'b0;
					frameDone <= inFrame && (fieldPos >= 2'h2);
					frameOk   <= rxCrcOk;
				end else if (inFrame) begin
					case (fieldPos)
						2'h0: frameAddr <= rxByte;
						2'h1: frameCtrl <= rxByte;
						2'h2: frameInfo <= rxByte;
						default: ;
					endcase
					if (fieldPos != 2'h3) begin
						fieldPos <= fieldPos + 2'h1;
					end
				end
			end
		end
	end
endmodule

`default_nettype wire

// ===== hdl/infrared_secondary_link_fsm.sv
// infrared_secondary_link_fsm: connection manager of a secondary station
// assumes byte decoder/encoder and host buffer logic on sys_clk (10 MHz)
`default_nettype none

module infrared_secondary_link_fsm #(
	parameter int unsigned TIMEOUT_CYCLES = link_pkg::TIMEOUT_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic [7:0] rxByte,
	input  wire logic       rxValid,
	input  wire logic       rxCrcOk,
	input  wire logic       txReady,
	input  wire logic       hostBufFull,
	output logic      [7:0] txByte,
	output logic            txValid,
	output logic            ctsN,
	output logic      [2:0] linkState,
	output logic      [1:0] linkRate
);
	link_pkg::link_state_t state;
	link_pkg::tx_state_t   txState;
	link_pkg::msg_t        txMsg;
	link_pkg::msg_t        replyMsg;
	logic        frameDone;
	logic  [7:0] frameAddr;
	logic  [7:0] frameCtrl;
	logic  [7:0] frameInfo;
	logic        frameOk;
	logic  [7:0] romData;
	logic  [4:0] txPtr;
	logic  [4:0] txPtrNext;
	logic  [2:0] txLeft;
	logic        txAccept;
	logic        txDone;
	logic        addrOk;
	logic        frameTake;
	logic        replyGo;
	logic        goDscv;
	logic        goConn;
	logic        goClose;
	logic        takeParams;
	logic  [2:0] iasHit;
	logic        xidSent;
	logic        paramsSet;
	logic  [2:0] iasDone;
	logic  [7:0] connAddr;
	logic        closePend;
	logic [31:0] idleCnt;
	logic        timeoutHit;
	logic        backToDisc;

	frame_parser u_parser (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.rxByte    (rxByte),
		.rxValid   (rxValid),
		.rxCrcOk   (rxCrcOk),
		.frameDone (frameDone),
		.frameAddr (frameAddr),
		.frameCtrl (frameCtrl),
		.frameInfo (frameInfo),
		.frameOk   (frameOk)
	);

	reply_rom u_rom (
		.sys_clk (sys_clk),
		.romAddr (txPtrNext),
		.romData (romData)
	);

	// only broadcast or our own connection address is ours; other
	// stations sharing the link are not served
	assign addrOk = (frameAddr == link_pkg::BCAST_ADDR) ||
		((state != link_pkg::ST_DISCONNECTED) && (frameAddr == connAddr));
	// half duplex: a frame is only handled while our transmitter is quiet
	assign frameTake = frameDone && addrOk &&
		(txState == link_pkg::TX_IDLE);
	assign txAccept = txValid && txReady;
	assign timeoutHit = (state != link_pkg::ST_DISCONNECTED) && !frameDone
		&& (idleCnt == 32'(TIMEOUT_CYCLES - 1));
	assign backToDisc = timeoutHit || (closePend && txDone);

	// reply decision per received frame, answered without the host
	always_comb begin
		replyGo    = 1'b0;
		replyMsg   = link_pkg::MSG_RR;
		goDscv     = 1'b0;
		goConn     = 1'b0;
		goClose    = 1'b0;
		takeParams = 1'b0;
		iasHit     = 3'h0;
		if (frameTake && !frameOk) begin
			if (state == link_pkg::ST_CONNECTED) begin
				replyGo  = 1'b1;
				replyMsg = link_pkg::MSG_REJ;
			end
		end else if (frameTake) begin
			case (state)
				link_pkg::ST_DISCONNECTED: begin
					if (frameCtrl == link_pkg::CTL_XID) begin
						if (frameInfo == link_pkg::SLOT_ZERO) begin
							replyGo  = 1'b1;
							replyMsg = link_pkg::MSG_XID;
						end else if (frameInfo == link_pkg::BCAST_SLOT) begin
							goDscv = xidSent;
						end
					end
				end
				link_pkg::ST_DISCOVERY: begin
					case (frameCtrl)
						link_pkg::CTL_XID: begin
							replyGo  = (frameInfo == link_pkg::SLOT_ZERO);
							replyMsg = link_pkg::MSG_XID;
						end
						link_pkg::CTL_SNRM: begin
							replyGo    = 1'b1;
							replyMsg   = link_pkg::MSG_PARAM;
							takeParams = 1'b1;
						end
						link_pkg::CTL_INFO: begin
							replyGo = paramsSet;
							case (frameInfo)
								link_pkg::QRY_NAME: begin
									replyMsg = link_pkg::MSG_NAME;
									iasHit   = 3'h1;
								end
								link_pkg::QRY_ADDR: begin
									replyMsg = link_pkg::MSG_ADDR;
									iasHit   = 3'h2;
								end
								link_pkg::QRY_CAPS: begin
									replyMsg = link_pkg::MSG_CAPS;
									iasHit   = 3'h4;
								end
								default: replyGo = 1'b0;
							endcase
						end
						link_pkg::CTL_RR: begin
							replyGo = 1'b1;
							goConn  = (iasDone == 3'h7);
						end
						link_pkg::CTL_DISC: begin
							replyGo  = 1'b1;
							replyMsg = link_pkg::MSG_UA;
							goClose  = 1'b1;
						end
						default: ;
					endcase
				end
				link_pkg::ST_CONNECTED: begin
					case (frameCtrl)
						link_pkg::CTL_RR,
						link_pkg::CTL_INFO: replyGo = 1'b1;
						link_pkg::CTL_DISC: begin
							replyGo  = 1'b1;
							replyMsg = link_pkg::MSG_UA;
							goClose  = 1'b1;
						end
						default: ;
					endcase
				end
				default: ;
			endcase
		end
	end

	// connection state; timeout and completed close win over advances
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state <= link_pkg::ST_DISCONNECTED;
		end else if (backToDisc) begin
			state <= link_pkg::ST_DISCONNECTED;
		end else if (goDscv) begin
			state <= link_pkg::ST_DISCOVERY;
		end else if (goConn) begin
			state <= link_pkg::ST_CONNECTED;
		end
	end

	// negotiation progress, forgotten whenever the link drops
	always_ff @(posedge sys_clk) begin
		if (!nrst || backToDisc) begin
			xidSent   <= 1'b0;
			paramsSet <= 1'b0;
			iasDone   <= 3'h0;
			connAddr  <= link_pkg::BCAST_ADDR;
			closePend <= 1'b0;
		end else begin
			if (txDone && (txMsg == link_pkg::MSG_XID)) begin
				xidSent <= 1'b1;
			end
			if (takeParams) begin
				paramsSet <= 1'b1;
				connAddr  <= frameInfo;
			end
			iasDone <= iasDone | iasHit;
			if (goClose) begin
				closePend <= 1'b1;
			end
		end
	end

	// next read address: the memory is registered, so it is fed ahead
	always_comb begin
		txPtrNext = txPtr;
		if (replyGo) begin
			txPtrNext = link_pkg::MSG_BASE[replyMsg];
		end else if (txAccept && ((txState == link_pkg::TX_BOF) ||
			((txState == link_pkg::TX_BODY) && (txLeft != 3'h0)))) begin
			txPtrNext = txPtr + 5'h01;
		end
	end

	// frame sender: start char, canned body, end char
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			txState <= link_pkg::TX_IDLE;
			txMsg   <= link_pkg::MSG_RR;
			txPtr   <= 5'h00;
			txLeft  <= 3'h0;
			txByte  <= 8'h00;
			txValid <= 1'b0;
			txDone  <= 1'b0;
		end else begin
			txPtr  <= txPtrNext;
			txDone <= 1'b0;
			case (txState)
				link_pkg::TX_IDLE: begin
					if (replyGo) begin
						txState <= link_pkg::TX_BOF;
						txMsg   <= replyMsg;
						txLeft  <= link_pkg::MSG_LEN[replyMsg];
						txByte  <= link_pkg::BOF_CHAR;
						txValid <= 1'b1;
					end
				end
				link_pkg::TX_BOF: begin
					if (txAccept) begin
						txState <= link_pkg::TX_BODY;
						txByte  <= romData;
						txLeft  <= txLeft - 3'h1;
					end
				end
				link_pkg::TX_BODY: begin
					if (txAccept && (txLeft == 3'h0)) begin
						txState <= link_pkg::TX_EOF;
						txByte  <= link_pkg::EOF_CHAR;
					end else if (txAccept) begin
						txByte <= romData;
						txLeft <= txLeft - 3'h1;
					end
				end
				link_pkg::TX_EOF: begin
					if (txAccept) begin
						txState <= link_pkg::TX_IDLE;
						txValid <= 1'b0;
						txDone  <= 1'b1;
					end
				end
				default: begin
					txState <= link_pkg::TX_IDLE;
					txValid <= 1'b0;
				end
			endcase
		end
	end

	// cycles since the last frame; a silent peer drops the link
	always_ff @(posedge sys_clk) begin
		// cleared on the timeout edge itself, so the count is already
		// zero when the state reads disconnected
		if (!nrst || frameDone || timeoutHit ||
			(state == link_pkg::ST_DISCONNECTED)) begin
			idleCnt <= 32'h0000_0000;
		end else begin
			idleCnt <= idleCnt + 32'h0000_0001;
		end
	end

	// host handshake: only data flow control, no modem control lines are
	// emulated; the host must honour it or its bytes are lost
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctsN <= 1'b1;
		end else begin
			ctsN <= !((state == link_pkg::ST_CONNECTED) && !hostBufFull);
		end
	end

	// status outputs; only one rate exists, so negotiation cannot move it
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			linkState <= link_pkg::ST_DISCONNECTED;
			linkRate  <= link_pkg::RATE_9600;
		end else begin
			linkState <= state;
			linkRate  <= link_pkg::RATE_9600;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	sequence sq_slot_zero;
		frameTake && frameOk && (state == link_pkg::ST_DISCONNECTED) &&
			(frameCtrl == link_pkg::CTL_XID) &&
			(frameInfo == link_pkg::SLOT_ZERO);
	endsequence
	sequence sq_poll_rr;
		frameTake && frameOk && (state == link_pkg::ST_CONNECTED) &&
			(frameCtrl == link_pkg::CTL_RR);
	endsequence
	sequence sq_close_done;
		closePend && txDone;
	endsequence

	a_cts_held_off: assert property (
		(state != link_pkg::ST_CONNECTED) |=> ctsN)
		else $error("clear-to-send open outside connected state");
	a_cts_buf_full: assert property (hostBufFull |=> ctsN)
		else $error("clear-to-send open with full host buffer");
	a_cts_open: assert property (
		(state == link_pkg::ST_CONNECTED) && !hostBufFull |=> !ctsN)
		else $error("clear-to-send closed while room remains");
	a_slot_zero_reply: assert property (
		sq_slot_zero |=> txValid && (txByte == link_pkg::BOF_CHAR)
			##1 (txMsg == link_pkg::MSG_XID))
		else $error("slot zero discovery not answered");
	a_discovery_entry: assert property (
		(state == link_pkg::ST_DISCOVERY) &&
			$past(state == link_pkg::ST_DISCONNECTED) |->
			$past(xidSent && frameDone && frameInfo == link_pkg::BCAST_SLOT))
		else $error("discovery entered without reply and id packet");
	a_keepalive_rr: assert property (
		sq_poll_rr |=> txValid ##1 (txMsg == link_pkg::MSG_RR))
		else $error("poll in connected state not answered");
	a_close_return: assert property (
		sq_close_done |=> (state == link_pkg::ST_DISCONNECTED) &&
			!closePend)
		else $error("close-link confirmed but link kept");
	a_timeout_drop: assert property (
		timeoutHit |=> (state == link_pkg::ST_DISCONNECTED) &&
			(idleCnt == 32'h0000_0000))
		else $error("no-frame timeout did not disconnect");
	a_eof_char: assert property (
		(txState == link_pkg::TX_EOF) |-> txValid &&
			(txByte == link_pkg::EOF_CHAR) && $past(txLeft == 3'h0))
		else $error("frame not closed by end character");
	a_modem_hint: assert property (
		(txState == link_pkg::TX_BODY) && (txLeft == 3'h0) &&
			(txMsg == link_pkg::MSG_XID) |->
			(txByte == link_pkg::HINT_MODEM))
		else $error("discovery reply lacks modem hint");
	a_rate_fixed: assert property (
		$rose(paramsSet) |-> ##1 (linkRate == link_pkg::RATE_9600))
		else $error("negotiated rate is not 9600");
	a_foreign_addr: assert property (
		frameDone && !addrOk && (txState == link_pkg::TX_IDLE) |=>
			!txValid)
		else $error("answered a frame for another station");
endmodule

`default_nettype wire

// ===== dv/primary_model.sv
// primary_model: far-side primary station that sends frames and takes
// replies; assumes the secondary's byte ports on sys_clk, moved at negedge
`default_nettype none

module primary_model (
	input  wire logic       sys_clk,
	output logic      [7:0] rxByte,
	output logic            rxValid,
	output logic            rxCrcOk,
	output logic            txReady,
	input  wire logic [7:0] txByte,
	input  wire logic       txValid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] gotQ[$];
	int         nFrames = 0;
	bit         slow = 1'b0;

	// idle line at time zero
	initial begin
		rxByte = 8'h3C;
		rxValid = 1'b0;
		rxCrcOk = 1'b0;
		txReady = 1'b1;
	end

	// one frame, a byte a cycle; the released line shows the inverse so
	// a stale byte cannot pass for a real one
	task automatic send(input logic [7:0] a, c, i, input logic ok);
		logic [7:0] f[5];
		f = '{8'hC0, a, c, i, 8'hC1};
		foreach (f[k]) begin
			@(negedge sys_clk);
			rxByte = f[k];
			rxValid = 1'b1;
			rxCrcOk = ok;
		end
		@(negedge sys_clk);
		rxValid = 1'b0;
		rxByte = ~rxByte;
	endtask

	// a slow encoder takes a byte only every other cycle
	always @(negedge sys_clk) txReady <= slow ? ~txReady : 1'b1;

	// record every accepted reply byte; the close char ends a frame
	always @(posedge sys_clk) begin
		if (txValid && txReady) begin
			gotQ.push_back(txByte);
			if (txByte == 8'hC1) nFrames++;
		end
	end
endmodule

`default_nettype wire

// ===== dv/tb_infrared_secondary_link_fsm.sv
// tb_infrared_secondary_link_fsm: discovery, connection, close and
// timeout against a primary model; assumes a shortened no-frame timeout
`default_nettype none

module tb_infrared_secondary_link_fsm;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned TMO = 50;
	logic       sys_clk = 1'b0;
	logic       nrst = 1'b0;
	logic       hostBufFull = 1'b0;
	logic [7:0] rxByte;
	logic [7:0] txByte;
	logic       rxValid;
	logic       rxCrcOk;
	logic       txReady;
	logic       txValid;
	logic       ctsN;
	logic [2:0] linkState;
	logic [1:0] linkRate;
	int         num_errors = 0;
	int         n_compared = 0;
	int         cycles = 0;

	infrared_secondary_link_fsm #(.TIMEOUT_CYCLES(TMO)) uut (
		.sys_clk(sys_clk), .nrst(nrst), .rxByte(rxByte),
		.rxValid(rxValid), .rxCrcOk(rxCrcOk), .txReady(txReady),
		.hostBufFull(hostBufFull), .txByte(txByte), .txValid(txValid),
		.ctsN(ctsN), .linkState(linkState), .linkRate(linkRate));

	primary_model pm (
		.sys_clk(sys_clk), .rxByte(rxByte), .rxValid(rxValid),
		.rxCrcOk(rxCrcOk), .txReady(txReady), .txByte(txByte),
		.txValid(txValid));

	// 100 ns period
	initial forever #50 sys_clk = ~sys_clk;

	// hang guard, far above the thousand or so cycles the run needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [7:0] seen, expd);
		n_compared++;
		if (seen !== expd) begin
			num_errors++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, expd);
		end
	endtask

	// wait for one reply frame, then compare it whole with its framing
	task automatic reply(input logic [7:0] body[$]);
		int n;
		n = pm.nFrames;
		repeat (200) begin
			if (pm.nFrames != n) break;
			@(posedge sys_clk);
		end
		body.push_front(8'hC0);
		body.push_back(8'hC1);
		check(8'(pm.gotQ.size()), 8'(body.size()));
		foreach (body[k]) check(pm.gotQ[k], body[k]);
		pm.gotQ.delete();
		repeat (4) @(negedge sys_clk);
	endtask

	// no reply may come for the frame just sent
	task automatic quiet();
		repeat (20) @(negedge sys_clk);
		check(8'(pm.gotQ.size()), 8'h00);
		pm.gotQ.delete();
	endtask

	task automatic t_reset();
		check(8'(linkState), 8'h01);
		check(8'(ctsN), 8'h01);
		check(8'(txValid), 8'h00);
		check(8'(linkRate), 8'h01);
		pm.send(8'hFF, 8'h3F, 8'hFF, 1'b1); // id before our reply
		quiet();
		check(8'(linkState), 8'h01);
		pm.send(8'hFF, 8'h3F, 8'h00, 1'b0); // bad check: no reply yet
		quiet();
		check(8'(linkState), 8'h01);
	endtask

	// close-link during discovery, then a silent discovery timing out
	task automatic t_abort();
		for (int r = 0; r < 2; r++) begin
			pm.send(8'hFF, 8'h3F, 8'h00, 1'b1);
			reply('{8'hFF, 8'hBF, 8'h00, 8'h04});
			pm.send(8'hFF, 8'h3F, 8'hFF, 1'b1);
			quiet();
			check(8'(linkState), 8'h02);
			if (r == 0) begin
				pm.send(8'hFF, 8'h53, 8'h00, 1'b1);
				reply('{8'hFF, 8'h73});
			end else begin
				repeat (60) @(negedge sys_clk);
			end
			check(8'(linkState), 8'h01);
			check(8'(ctsN), 8'h01);
		end
	endtask

	// polling, negotiation and service queries up to the connected state
	task automatic t_connect(input bit slowTx);
		logic [7:0] ans[3];
		ans = '{8'h53, 8'h03, 8'h04};
		pm.slow = slowTx;
		for (int s = 0; s < 6; s++) begin
			pm.send(8'hFF, 8'h3F, 8'(s), 1'b1);
			if (s == 0) reply('{8'hFF, 8'hBF, 8'h00, 8'h04});
			else quiet();
		end
		pm.send(8'hFF, 8'h3F, 8'hFF, 1'b1);
		quiet();
		check(8'(linkState), 8'h02);
		pm.send(8'hFF, 8'h3F, 8'h00, 1'b1);
		reply('{8'hFF, 8'hBF, 8'h00, 8'h04});
		pm.send(8'hFF, 8'h93, 8'h5A, 1'b1);
		reply('{8'hFF, 8'h73, 8'h01, 8'h01, 8'h02});
		check(8'(linkRate), 8'h01);
		for (int q = 1; q < 4; q++) begin
			pm.send(8'h5A, 8'h10, 8'(q), 1'b1);
			reply('{8'hFF, 8'h10, 8'(q), ans[q-1]});
		end
		check(8'(ctsN), 8'h01);
		pm.send(8'h5A, 8'h11, 8'h00, 1'b1);
		reply('{8'hFF, 8'h11});
		check(8'(linkState), 8'h04);
		check(8'(ctsN), 8'h00);
		pm.slow = 1'b0;
	endtask

	// flow control, error report, foreign station and close-link
	task automatic t_data();
		hostBufFull = 1'b1; // host holds off while ctsN is high
		repeat (3) @(negedge sys_clk);
		check(8'(ctsN), 8'h01);
		hostBufFull = 1'b0;
		pm.send(8'h5A, 8'h10, 8'h07, 1'b0);
		reply('{8'hFF, 8'h19});
		pm.send(8'h33, 8'h11, 8'h00, 1'b1);
		quiet();
		pm.send(8'h5A, 8'h10, 8'h07, 1'b1);
		reply('{8'hFF, 8'h11});
		check(8'(ctsN), 8'h00);
		pm.send(8'h5A, 8'h53, 8'h00, 1'b1);
		reply('{8'hFF, 8'h73});
		check(8'(linkState), 8'h01);
		check(8'(ctsN), 8'h01);
	endtask

	// silence on the link drops the connection once the count runs out
	task automatic t_timeout();
		repeat (30) @(negedge sys_clk);
		check(8'(linkState), 8'h04);
		repeat (40) @(negedge sys_clk);
		check(8'(linkState), 8'h01);
		check(8'(ctsN), 8'h01);
	endtask

	task automatic tally_and_finish();
		$display("mismatches %0d, compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// reset for 8 cycles, released off the sampling edge
	initial begin
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		nrst = 1'b1;
		t_reset();
		t_connect(1'b1);
		t_data();
		t_connect(1'b0);
		t_timeout();
		t_abort();
		tally_and_finish();
	end
endmodule

`default_nettype wire
